// File: jpm_pkg.sv
// Purpose: shared constants and types for the justified pulse modulator
// Assumes: one clock domain, synchronous active-high reset
// Notes:   one dot period is resolved into PERIOD_LAST + 1 clock slots
package jpm_pkg;

  // ****************************************
  // period and code geometry
  // ****************************************
  localparam int unsigned CODE_W       = 8;
  localparam int unsigned POS_W        = 8;
  localparam logic [7:0]  PERIOD_LAST  = 8'hfe;   // slots 0..254, 255 per period
  localparam logic [7:0]  CODE_FULL    = 8'hff;   // always-high code
  localparam logic [7:0]  CODE_ZERO    = 8'h00;   // always-low code
  localparam logic [7:0]  CENTER_POS   = 8'h7f;   // middle slot of a period

  // ****************************************
  // calibration figures
  // ****************************************
  localparam int unsigned CAL_STEP_CLOCKS = 32;   // clocks per trim step
  localparam int unsigned CAL_MAX_INCR    = 64;   // most trim increments
  localparam int unsigned TRIM_W          = 7;    // holds 0..64
  localparam logic [6:0]  TRIM_MIN        = 7'h00;
  localparam logic [4:0]  DIV_ZERO        = 5'h00;

  // placement modes
  typedef enum logic [1:0] {
    JPM_LEADING  = 2'b00,
    JPM_TRAILING = 2'b01,
    JPM_DUAL     = 2'b10
  } jpm_mode_t;

  // calibration sequencer states
  typedef enum logic [1:0] {
    JPM_CAL_IDLE = 2'b00,
    JPM_CAL_INIT = 2'b01,
    JPM_CAL_RUN  = 2'b10,
    JPM_CAL_DONE = 2'b11
  } jpm_cal_state_t;

  // one period's worth of modulation input
  typedef struct packed {
    logic [7:0] code;
    logic       edge_count_select;   // 1 single edge, 0 dual edge
    logic       edge_side_select;    // 1 leading, 0 trailing
  } jpm_word_t;

  localparam jpm_word_t WORD_IDLE = '{code: 8'h00, edge_count_select: 1'b0,
                                      edge_side_select: 1'b0};

endpackage

// File: jpm_top.sv
// Purpose: digital model of a per-period pulse width modulator with ramp autocalibration
// Assumes: inputs synchronous to ref_clk_in; one dot period is 255 clock slots
// Notes:   output is registered, so each slot shows one clock after its position count

// How it works
// - each period carries one pulse whose width grows with the 8-bit code
// - single-edge select and side select choose leading, trailing or dual edge
// - leading mode: rising edge delayed by 255 minus code, falling edge at period end
// - trailing mode: rising edge at period start, falling edge delayed by code
// - dual mode: both edges move, pulse centre stays fixed
// - code and control may change every period and each value is used
// - code and control are captured on the period boundary edge
// - two capture stages, so the pulse appears one period after capture
// - code 255 gives a full-period high regardless of control
// - code is plain unsigned binary, msb weighs most
// - request high initialises logic; its falling edge starts calibration
// - calibration ignores code and control values
// - calibration start sets the ramp trim to minimum, slowest ramp
// - trim rises one step every 32nd clock until ramp matches period
// - done output rises once the ramp reaches its low threshold in time
// - at most 64 trim increments, bounding calibration to 32 x 64 clocks
// - code 0 gives a full-period low
// - low-power request at 0 forces the output low; counters and pipeline keep running
module jpm_top
  import jpm_pkg::*;
#(
  parameter int unsigned STEP_CLOCKS = CAL_STEP_CLOCKS,
  parameter int unsigned MAX_INCR    = CAL_MAX_INCR
) (
  input  wire logic                ref_clk_in,
  input  wire logic                reset_in,
  input  wire jpm_pkg::jpm_word_t  word_in,
  input  wire logic                cal_request_in,
  input  wire logic                low_power_n_in,
  input  wire logic [6:0]          ramp_match_trim_in,
  output logic                     pwm_out,
  output logic                     period_edge_out,
  output logic                     cal_done_out,
  output logic [6:0]               ramp_trim_out
);
  import jpm_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  // the divider and trim counters are fixed at 5 and 7 bits
  if (STEP_CLOCKS != CAL_STEP_CLOCKS ||
      MAX_INCR < 1 || MAX_INCR > CAL_MAX_INCR) begin : g_bad_params
    $error("jpm_top: STEP_CLOCKS must be 32 and MAX_INCR within 1..64");
  end

  localparam logic [4:0] DIV_LAST = 5'(STEP_CLOCKS - 1);
  localparam logic [6:0] TRIM_MAX = 7'(MAX_INCR);

  // ****************************************
  // decode helpers
  // ****************************************
  // mode decode, shared by the shaper and the checks
  function automatic jpm_mode_t mode_of(input jpm_word_t w);
    if (!w.edge_count_select) begin
      mode_of = JPM_DUAL;
    end else if (w.edge_side_select) begin
      mode_of = JPM_LEADING;
    end else begin
      mode_of = JPM_TRAILING;
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0]     pos_ff;
  jpm_word_t      stage1_ff;
  jpm_word_t      stage2_ff;
  logic           out_ff;
  logic           req_prev_ff;
  jpm_cal_state_t cal_ff;
  logic [4:0]     div_ff;
  logic [6:0]     trim_ff;
  logic           done_ff;

  // ****************************************
  // period timing and capture
  // ****************************************
  wire        boundary   = (pos_ff == PERIOD_LAST);
  wire        init_now   = cal_request_in;
  wire [7:0]  nxt_pos    = boundary ? 8'h00 : pos_ff + 8'h01;

  // the boundary edge captures new inputs; init clears the pipeline
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || init_now) begin
      pos_ff    <= 8'h00;
      stage1_ff <= WORD_IDLE;
      stage2_ff <= WORD_IDLE;
    end else begin
      pos_ff <= nxt_pos;
      if (boundary) begin
        stage1_ff <= word_in;
        stage2_ff <= stage1_ff;
      end
    end
  end

  // ****************************************
  // pulse shaping
  // ****************************************
  // widths are code slots out of 255, so code 255 covers the period
  wire jpm_mode_t mode_now   = mode_of(stage2_ff);
  wire [7:0]      code_now   = stage2_ff.code;
  wire [7:0]      lead_start = CODE_FULL - code_now;
  wire [7:0]      dual_start = {1'b0, lead_start[7:1]};
  wire [8:0]      dual_end   = {1'b0, dual_start} + {1'b0, code_now};
  wire            lead_hi    = (pos_ff >= lead_start);
  wire            trail_hi   = (pos_ff < code_now);
  wire            dual_hi    = (pos_ff >= dual_start) &&
                               ({1'b0, pos_ff} < dual_end);
  wire            full_hi    = (code_now == CODE_FULL);
  wire            zero_lo    = (code_now == CODE_ZERO);

  logic shape_hi;
  // pick the edge placement for this period
  always_comb begin
    unique case (mode_now)
      JPM_LEADING:  shape_hi = lead_hi;
      JPM_TRAILING: shape_hi = trail_hi;
      JPM_DUAL:     shape_hi = dual_hi;
      default:      shape_hi = 1'b0;
    endcase
  end

  // low-power stops the output; the pipeline keeps running so no stale data
  wire nxt_out = low_power_n_in && !init_now && !zero_lo &&
                 (full_hi || shape_hi);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // ****************************************
  // calibration sequencer
  // ****************************************
  wire req_fall   = req_prev_ff && !cal_request_in;
  wire step_tick  = (div_ff == DIV_LAST);
  // ramp is fast enough once the trim reaches the matching setting
  wire ramp_fits  = (trim_ff >= ramp_match_trim_in);
  wire trim_limit = (trim_ff == TRIM_MAX);

  jpm_cal_state_t nxt_cal;
  // the sequence looks only at request, trim and divider, never the data
  always_comb begin
    nxt_cal = cal_ff;
    unique case (cal_ff)
      JPM_CAL_IDLE: if (cal_request_in) nxt_cal = JPM_CAL_INIT;
      JPM_CAL_INIT: if (req_fall) nxt_cal = JPM_CAL_RUN;
      JPM_CAL_RUN: begin
        if (cal_request_in) begin
          nxt_cal = JPM_CAL_INIT;
        end else if (ramp_fits || trim_limit) begin
          nxt_cal = JPM_CAL_DONE;
        end
      end
      JPM_CAL_DONE: if (cal_request_in) nxt_cal = JPM_CAL_INIT;
    endcase
  end

  // trim restarts at the slowest ramp on the falling edge of the request
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cal_ff      <= JPM_CAL_IDLE;
      req_prev_ff <= 1'b0;
      div_ff      <= DIV_ZERO;
      trim_ff     <= TRIM_MIN;
      done_ff     <= 1'b0;
    end else begin
      cal_ff      <= nxt_cal;
      req_prev_ff <= cal_request_in;
      if (cal_request_in || req_fall) begin
        div_ff  <= DIV_ZERO;
        trim_ff <= TRIM_MIN;
        done_ff <= 1'b0;
      end else if (cal_ff == JPM_CAL_RUN) begin
        div_ff <= div_ff + 5'h01;
        if (ramp_fits || trim_limit) begin
          done_ff <= 1'b1;
        end else if (step_tick) begin
          trim_ff <= trim_ff + 7'h01;
        end
      end
    end
  end

  assign pwm_out         = out_ff;
  assign period_edge_out = boundary;
  assign cal_done_out    = done_ff;
  assign ramp_trim_out   = trim_ff;

  // ****************************************
  // checks
  // ****************************************
  // each output check judges a slot one clock after its count, since the output is registered
  a_zero_code_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (code_now == CODE_ZERO) |=> !pwm_out)
    else $error("code 0 produced a high slot");

  a_full_code_high: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (full_hi && low_power_n_in && !cal_request_in) |=> pwm_out)
    else $error("code 255 produced a low slot");

  a_trail_start_high: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (mode_now == JPM_TRAILING && !zero_lo && pos_ff == 8'h00 &&
     low_power_n_in && !cal_request_in) |=> pwm_out)
    else $error("trailing pulse missing at period start");

  a_lead_end_high: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (mode_now == JPM_LEADING && !zero_lo && boundary &&
     low_power_n_in && !cal_request_in) |=> pwm_out)
    else $error("leading pulse missing at period end");

  a_dual_center: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (mode_now == JPM_DUAL && !zero_lo && pos_ff == CENTER_POS &&
     low_power_n_in && !cal_request_in) |=> pwm_out)
    else $error("dual pulse missing at period centre");

  a_double_latch: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (boundary && !cal_request_in) |=> (stage2_ff == $past(stage1_ff)) &&
                                      (stage1_ff == $past(word_in)))
    else $error("capture pipeline did not advance");

  a_trim_step: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (cal_ff == JPM_CAL_RUN && step_tick && !ramp_fits && !trim_limit &&
     !cal_request_in) |=> trim_ff == $past(trim_ff) + 7'h01)
    else $error("trim did not step on the 32nd clock");

  a_trim_minimum: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    req_fall |=> trim_ff == TRIM_MIN && cal_ff == JPM_CAL_RUN)
    else $error("calibration did not start from minimum trim");

  a_done_holds: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (cal_done_out && !cal_request_in) |=> cal_done_out && $stable(ramp_trim_out))
    else $error("done or trim changed without a request");

  a_trim_bound: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    trim_ff <= TRIM_MAX)
    else $error("trim exceeded its increment limit");

  a_low_power_off: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !low_power_n_in |=> !pwm_out)
    else $error("output high in low power");

  // width edges: the slot just outside each pulse (before it in leading mode, after it otherwise) must read low
  a_trail_end_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (mode_now == JPM_TRAILING && !full_hi && pos_ff == code_now) |=> !pwm_out)
    else $error("trailing pulse ran past its width");

  a_lead_start_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (mode_now == JPM_LEADING && !full_hi && pos_ff + 8'h01 == lead_start) |=> !pwm_out)
    else $error("leading pulse rose too early");

  a_dual_end_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (mode_now == JPM_DUAL && !full_hi && {1'b0, pos_ff} == dual_end) |=> !pwm_out)
    else $error("dual pulse ran past its width");

  // request, capture and sequencer behaviour
  a_init_clears: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    cal_request_in |=> !pwm_out && !cal_done_out && ramp_trim_out == TRIM_MIN &&
                       stage1_ff == WORD_IDLE && stage2_ff == WORD_IDLE)
    else $error("calibrate request did not initialise the logic");

  a_capture_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!boundary && !cal_request_in) |=> $stable(stage1_ff) && $stable(stage2_ff))
    else $error("captured word moved off the boundary edge");

  a_no_run_early: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (cal_ff == JPM_CAL_INIT && cal_request_in) |=> cal_ff == JPM_CAL_INIT)
    else $error("calibration began before the request fell");

  a_trim_between: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (cal_ff == JPM_CAL_RUN && !step_tick && !cal_request_in) |=> $stable(ramp_trim_out))
    else $error("trim stepped off the 32nd clock");

  a_done_rises: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (cal_ff == JPM_CAL_RUN && ramp_fits && !cal_request_in) |=> cal_done_out)
    else $error("done did not rise once the ramp fit");

  a_limit_done: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (cal_ff == JPM_CAL_RUN && trim_limit && !cal_request_in) |=>
      cal_done_out && $stable(ramp_trim_out))
    else $error("trim limit did not end calibration");

  a_period_wraps: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (boundary && !cal_request_in) |=> pos_ff == 8'h00)
    else $error("period did not wrap after 255 slots");

endmodule

// File: jpma_ctrl_model.sv
// Purpose: printer controller model feeding words and calibrate requests
// Assumes: one word per period, changed right after each boundary edge
// Notes:   idle words are all low, so no pulses leak out during calibration
module jpma_ctrl_model (
  input  wire logic          ref_clk_in,
  input  wire logic          period_edge_in,
  output jpm_pkg::jpm_word_t word_out,
  output logic               cal_request_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import jpm_pkg::*;

  // ****************************************
  // word feed and calibrate request
  // ****************************************
  jpm_word_t q[$];
  jpm_word_t fill_word = WORD_IDLE;
  jpm_word_t word_ff   = WORD_IDLE;
  logic      req_ff    = 1'b0;

  // one writer per signal, so the feed and the request never collide
  assign word_out        = word_ff;
  assign cal_request_out = req_ff;

  // a new word each period, so the capture edge never sees it move;
  // while the request is high the fill word goes out at once
  always @(posedge ref_clk_in) begin
    if (period_edge_in || req_ff) begin
      word_ff <= (q.size() > 0) ? q.pop_front() : fill_word;
    end
  end

  // quiet holds inputs low; busy keeps a full code to show it is ignored
  task automatic calibrate(input int len, input bit quiet);
    fill_word = quiet ? WORD_IDLE : jpm_word_t'{code: 8'hff, edge_count_select: 1'b1,
                                                edge_side_select: 1'b1};
    req_ff <= 1'b1;
    repeat (len) @(posedge ref_clk_in);
    req_ff <= 1'b0;
  endtask
endmodule

// File: tb_justified_pulse_modulator_autocal.sv
// Purpose: self-checking bench for the justified pulse modulator
// Assumes: 125 MHz clock, controller model on the word and request inputs
// Notes:   ramp fit is modelled by a trim threshold set from the bench
module tb_justified_pulse_modulator_autocal;
  timeunit 1ns;
  timeprecision 1ps;
  import jpm_pkg::*;

  `define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end

  // ****************************************
  // signals and instances
  // ****************************************
  logic       ref_clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       low_power_n_in = 1'b1;
  logic [6:0] ramp_match_trim_in = 7'h03;
  jpm_word_t  word_in;
  jpm_word_t  ws[$];
  logic       cal_request_in;
  logic       pwm_out;
  logic       period_edge_out;
  logic       cal_done_out;
  logic [6:0] ramp_trim_out;
  logic [7:0] code_tab [6] = '{8'h00, 8'h01, 8'h5a, 8'h80, 8'hfe, 8'hff};
  logic [1:0] ctl_tab [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
  int         mismatches = 0;
  int         n_tests = 0;
  int         n_first;
  int         n;

  // clock never stops, calibration depends on it
  initial forever #4 ref_clk_in = ~ref_clk_in;

  jpm_top uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .word_in(word_in),
    .cal_request_in(cal_request_in), .low_power_n_in(low_power_n_in),
    .ramp_match_trim_in(ramp_match_trim_in), .pwm_out(pwm_out),
    .period_edge_out(period_edge_out), .cal_done_out(cal_done_out),
    .ramp_trim_out(ramp_trim_out));

  jpma_ctrl_model ctl (.ref_clk_in(ref_clk_in), .period_edge_in(period_edge_out),
    .word_out(word_in), .cal_request_out(cal_request_in));

  // ****************************************
  // expectations and tasks
  // ****************************************
  // expected level of slot p; width is code slots of 255
  function automatic logic exp_bit(jpm_word_t w, int p);
    int c = w.code;
    int s = (255 - c) >> 1;
    if (!w.edge_count_select) return (p >= s) && (p < s + c);
    if (w.edge_side_select) return p >= 255 - c;
    return p < c;
  endfunction

  // words go out back to back; output lags capture by one full period
  // the count runs one slot ahead of the output, so the boundary shows at slot 253
  task automatic run_words(input jpm_word_t wq[$], input logic lp);
    do @(negedge ref_clk_in); while (period_edge_out !== 1'b1);
    foreach (wq[i]) ctl.q.push_back(wq[i]);
    repeat (512) @(posedge ref_clk_in);
    foreach (wq[i]) begin
      for (int p = 0; p < 255; p++) begin
        @(negedge ref_clk_in);
        `CHK(pwm_out, exp_bit(wq[i], p) & lp)
        `CHK(period_edge_out, p == 253)
        @(posedge ref_clk_in);
      end
    end
  endtask

  // one calibration; counts cycles from request release to done
  task automatic cal_run(input bit quiet, output int cnt);
    @(posedge ref_clk_in);
    ctl.calibrate(130, quiet);
    @(negedge ref_clk_in);
    `CHK(ramp_trim_out, TRIM_MIN)
    `CHK({cal_done_out, pwm_out}, 2'b00)
    cnt = 0;
    while (cal_done_out !== 1'b1 && cnt < 3000) begin
      @(negedge ref_clk_in);
      cnt++;
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    foreach (ctl_tab[m]) foreach (code_tab[c]) ws.push_back(jpm_word_t'{code: code_tab[c],
      edge_count_select: ctl_tab[m][1], edge_side_select: ctl_tab[m][0]});
    repeat (4) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(negedge ref_clk_in);
    `CHK({pwm_out, cal_done_out, ramp_trim_out}, 9'h000)
    run_words(ws, 1'b1);
    low_power_n_in <= 1'b0;
    run_words(ws[5:5], 1'b0);
    @(posedge ref_clk_in);
    low_power_n_in <= 1'b1;
    cal_run(1'b1, n_first);
    `CHK(n_first >= 96 && n_first <= 100, 1'b1)
    `CHK(ramp_trim_out, 7'h03)
    `CHK(pwm_out, 1'b0)
    repeat (300) @(negedge ref_clk_in);
    `CHK({cal_done_out, ramp_trim_out}, 8'h83)
    cal_run(1'b0, n);
    `CHK(n, n_first)
    @(posedge ref_clk_in);
    ramp_match_trim_in <= 7'h7f;
    cal_run(1'b1, n);
    `CHK(n >= 2048 && n <= 2052, 1'b1)
    `CHK(ramp_trim_out, 7'h40)
    complete_run();
  end

  // the whole run needs about 11000 cycles
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
